// ---- rtl/jtag_config_loader.sv ----
// test-port configuration loader: instruction decode, data registers, load control
`timescale 1ns/1ns
module jtag_config_loader
  import jtag_cfg_pkg::*;
#(
  parameter int BSR_W = BSR_W_DEF,
  parameter int BUF_DEPTH = BUF_DEPTH_DEF,
  parameter logic [ID_W-1:0] ID_CODE = ID_CODE_DEF
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic tck,
  input wire logic tap_reset,
  input wire tap_ctl_type tap_ctl,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic reconfig_request_n,
  input wire logic chip_enable_in_n,
  output logic chain_enable_out_n,
  input wire logic dev_reset_n,
  input wire logic dev_oe,
  input wire logic ext_load_active,
  output logic ext_load_abort,
  input wire logic ext_decomp_req,
  output logic decompress_en,
  input wire logic cfg_loaded,
  output logic [BYTE_W-1:0] cfg_word,
  output logic cfg_valid,
  input wire logic cfg_ready,
  output logic cfg_clear,
  output logic config_complete,
  input wire logic [BSR_W-1:0] io_pin_in,
  output logic [BSR_W-1:0] io_test_out,
  output logic io_test_en,
  output logic user_oe,
  output logic user_reset_n,
  output logic overrun
);

  if (BSR_W < 1) begin : g_chk
    $error("boundary register width must be at least 1");
  end

  // ---------------------------------------------------------------
  // test clock domain: synchronisers
  // ---------------------------------------------------------------
  logic [2:0] c2t_s1_q;
  logic [2:0] c2t_s2_q;
  logic [BSR_W-1:0] pin_s1_q;
  logic [BSR_W-1:0] pin_s2_q;
  logic done_s;
  logic halt_s;
  logic init_run_s;
  cfg_state_type state_q;
  logic ack_q;

  always_ff @(posedge tck) begin
    if (tap_reset) begin
      c2t_s1_q <= '0;
      c2t_s2_q <= '0;
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      c2t_s1_q <= {state_q[3], state_q[4], state_q[2]};
      c2t_s2_q <= c2t_s1_q;
      pin_s1_q <= io_pin_in;
      pin_s2_q <= pin_s1_q;
    end
  end
  assign done_s = c2t_s2_q[2];
  assign halt_s = c2t_s2_q[1];
  assign init_run_s = c2t_s2_q[0];

  // ---------------------------------------------------------------
  // instruction register and I/O takeover
  // ---------------------------------------------------------------
  logic [IR_W-1:0] ir_sr_q;
  logic [IR_W-1:0] ir_q;
  logic [IR_W-1:0] ir_eff;
  logic restricted;
  logic io_taken_q;
  logic halt_prev_q;

  always_ff @(posedge tck) begin
    if (tap_reset) begin
      ir_sr_q <= IR_CAPTURE;
      ir_q <= OP_IDCODE;
    end else begin
      if (tap_ctl.capture_ir) begin
        ir_sr_q <= IR_CAPTURE;
      end else if (tap_ctl.shift_ir) begin
        ir_sr_q <= {tdi, ir_sr_q[IR_W-1:1]};
      end
      if (tap_ctl.update_ir) begin
        ir_q <= ir_sr_q;
      end
    end
  end

  always_comb begin
    case (ir_q)
      OP_BYPASS, OP_IDCODE, OP_SAMPLE, OP_CONFIG_IO, OP_PULSE_CONFIG, OP_PROGRAM,
      OP_CHECK_STATUS: restricted = 1'b0;
      default: restricted = 1'b1;
    endcase
  end
  assign ir_eff = (restricted && !io_taken_q) ? OP_BYPASS : ir_q;

  always_ff @(posedge tck) begin
    if (tap_reset) begin
      io_taken_q <= 1'b0;
      halt_prev_q <= 1'b0;
    end else begin
      halt_prev_q <= halt_s;
      if (tap_ctl.update_ir && ir_sr_q == OP_CONFIG_IO) begin
        io_taken_q <= 1'b1;
      end else if (halt_prev_q && !halt_s) begin
        io_taken_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // data registers
  // ---------------------------------------------------------------
  logic bypass_q;
  logic status_q;
  logic [ID_W-1:0] id_sr_q;
  logic [BSR_W-1:0] bsr_q;
  logic [BSR_W-1:0] bsr_upd_q;

  always_ff @(posedge tck) begin
    if (tap_reset) begin
      bypass_q <= 1'b0;
      status_q <= 1'b0;
      id_sr_q <= '0;
      bsr_q <= '0;
      bsr_upd_q <= '0;
    end else if (tap_ctl.capture_dr) begin
      bypass_q <= 1'b0;
      status_q <= done_s;
      id_sr_q <= ID_CODE;
      bsr_q <= pin_s2_q;
    end else if (tap_ctl.shift_dr) begin
      bypass_q <= tdi;
      status_q <= tdi;
      id_sr_q <= {tdi, id_sr_q[ID_W-1:1]};
      bsr_q <= {tdi, bsr_q[BSR_W-1:1]};
    end else if (tap_ctl.update_dr && ir_eff == OP_EXTEST) begin
      bsr_upd_q <= bsr_q;
    end
  end
  assign io_test_out = bsr_upd_q;
  assign io_test_en = io_taken_q && ir_eff == OP_EXTEST;

  // ---------------------------------------------------------------
  // bitstream bytes and event toggles toward the system clock
  // ---------------------------------------------------------------
  logic [BYTE_W-1:0] byte_sr_q;
  logic [BYTE_W-1:0] hold_q;
  logic [2:0] bit_cnt_q;
  logic req_tgl_q;
  logic [1:0] ack_s_q;
  logic [2:0] ev_tgl_q;
  logic pending;
  logic overrun_q;

  assign pending = req_tgl_q != ack_s_q[1];

  always_ff @(posedge tck) begin
    if (tap_reset) begin
      byte_sr_q <= '0;
      hold_q <= '0;
      bit_cnt_q <= '0;
      req_tgl_q <= 1'b0;
      ack_s_q <= '0;
      overrun_q <= 1'b0;
    end else begin
      ack_s_q <= {ack_s_q[0], ack_q};
      if (tap_ctl.capture_dr) begin
        bit_cnt_q <= '0;
      end else if (tap_ctl.shift_dr && ir_eff == OP_PROGRAM) begin
        byte_sr_q <= {tdi, byte_sr_q[BYTE_W-1:1]};
        bit_cnt_q <= bit_cnt_q + 1'b1;
        if (bit_cnt_q == 3'h7) begin
          if (pending) begin
            overrun_q <= 1'b1;
          end else begin
            hold_q <= {tdi, byte_sr_q[BYTE_W-1:1]};
            req_tgl_q <= ~req_tgl_q;
          end
        end
      end
    end
  end
  assign overrun = overrun_q;

  always_ff @(posedge tck) begin
    if (tap_reset) begin
      ev_tgl_q <= '0;
    end else if (tap_ctl.update_ir) begin
      ev_tgl_q <= ev_tgl_q ^ {ir_sr_q == OP_PROGRAM, ir_sr_q == OP_CONFIG_IO,
                              ir_sr_q == OP_PULSE_CONFIG};
    end
  end

  // ---------------------------------------------------------------
  // initialization clock count
  // ---------------------------------------------------------------
  logic [7:0] init_cnt_q;
  logic init_done_q;

  always_ff @(posedge tck) begin
    if (tap_reset || !init_run_s) begin
      init_cnt_q <= '0;
      init_done_q <= 1'b0;
    end else if (init_cnt_q != INIT_TCK_CYCLES) begin
      init_cnt_q <= init_cnt_q + 1'b1;
    end else begin
      init_done_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // serial output on the falling edge
  // ---------------------------------------------------------------
  logic tdo_d;

  always_comb begin
    tdo_d = bypass_q;
    if (tap_ctl.shift_ir) begin
      tdo_d = ir_sr_q[0];
    end else begin
      case (ir_eff)
        OP_IDCODE: tdo_d = id_sr_q[0];
        OP_SAMPLE, OP_EXTEST: tdo_d = bsr_q[0];
        OP_CHECK_STATUS: tdo_d = status_q;
        default: tdo_d = bypass_q;
      endcase
    end
  end

  always_ff @(negedge tck) begin
    if (tap_reset) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo <= tdo_d;
      tdo_oe <= tap_ctl.shift_ir | tap_ctl.shift_dr;
    end
  end

  // ---------------------------------------------------------------
  // system clock domain: synchronisers and events
  // ---------------------------------------------------------------
  logic [5:0] pin_sys_s1_q;
  logic [5:0] pin_sys_s2_q;
  logic [3:0] t2c_s1_q;
  logic [3:0] t2c_s2_q;
  logic [2:0] ev_prev_q;
  logic [2:0] ev;
  logic req_s;
  logic recfg_prev_q;
  logic pin_rise;

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_sys_s1_q <= PIN_SYNC_RST;
      pin_sys_s2_q <= PIN_SYNC_RST;
      t2c_s1_q <= '0;
      t2c_s2_q <= '0;
      ev_prev_q <= '0;
      recfg_prev_q <= 1'b1;
    end else begin
      pin_sys_s1_q <= {reconfig_request_n, chip_enable_in_n, dev_reset_n, dev_oe,
                       ext_load_active, ext_decomp_req};
      pin_sys_s2_q <= pin_sys_s1_q;
      t2c_s1_q <= {init_done_q, ev_tgl_q};
      t2c_s2_q <= t2c_s1_q;
      ev_prev_q <= t2c_s2_q[2:0];
      recfg_prev_q <= pin_sys_s2_q[5];
    end
  end
  assign ev = t2c_s2_q[2:0] ^ ev_prev_q;
  assign pin_rise = pin_sys_s2_q[5] && !recfg_prev_q;

  // ---------------------------------------------------------------
  // configuration control
  // ---------------------------------------------------------------
  cfg_state_type state_d;
  logic recfg_low;

  assign recfg_low = !pin_sys_s2_q[5];

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_UNCONF: begin
        if (ev[2] && !recfg_low && !pin_sys_s2_q[4]) begin
          state_d = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (recfg_low) begin
          state_d = ST_UNCONF;
        end else if (cfg_loaded && !cfg_valid) begin
          state_d = ST_INIT;
        end
      end
      ST_INIT: begin
        if (recfg_low) begin
          state_d = ST_UNCONF;
        end else if (t2c_s2_q[3]) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        if (recfg_low) begin
          state_d = ST_UNCONF;
        end else if (ev[2]) begin
          state_d = ST_LOAD;
        end
      end
      ST_HALT: begin
        if (ev[0] || pin_rise) begin
          state_d = ST_UNCONF;
        end
      end
      default: state_d = ST_UNCONF;
    endcase
    if (ev[1]) begin
      state_d = ST_HALT;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ST_UNCONF;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      config_complete <= 1'b0;
      chain_enable_out_n <= 1'b1;
      cfg_clear <= 1'b0;
      ext_load_abort <= 1'b0;
      decompress_en <= 1'b0;
      user_oe <= 1'b0;
      user_reset_n <= 1'b0;
    end else begin
      config_complete <= state_d == ST_DONE;
      chain_enable_out_n <= state_d != ST_DONE;
      cfg_clear <= state_q != state_d && (state_d == ST_UNCONF || state_d == ST_HALT ||
                   state_d == ST_LOAD);
      ext_load_abort <= state_d == ST_LOAD && state_q != ST_LOAD && pin_sys_s2_q[1];
      decompress_en <= pin_sys_s2_q[0] && state_d != ST_LOAD && state_d != ST_INIT;
      user_oe <= pin_sys_s2_q[2] && state_d == ST_DONE;
      user_reset_n <= pin_sys_s2_q[3];
    end
  end

  // ---------------------------------------------------------------
  // byte handshake into the buffer
  // ---------------------------------------------------------------
  logic req_s1_q;
  logic req_s2_q;
  logic buf_ready;
  logic take;

  always_ff @(posedge clk) begin
    if (srst) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
    end else begin
      req_s1_q <= req_tgl_q;
      req_s2_q <= req_s1_q;
    end
  end
  assign req_s = req_s2_q;
  assign take = req_s != ack_q && (buf_ready || state_q != ST_LOAD);

  always_ff @(posedge clk) begin
    if (srst) begin
      ack_q <= 1'b0;
    end else if (take) begin
      ack_q <= req_s;
    end
  end

  cfg_buffer #(.WIDTH(BYTE_W), .DEPTH(BUF_DEPTH)) u_buf (
    .clk(clk),
    .srst(srst),
    .in_data(hold_q),
    .in_valid(take && state_q == ST_LOAD),
    .in_ready(buf_ready),
    .out_data(cfg_word),
    .out_valid(cfg_valid),
    .out_ready(cfg_ready)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_bypass_one_bit;
    @(posedge tck) disable iff (tap_reset)
      tap_ctl.shift_dr && !tap_ctl.capture_dr && ir_eff == OP_BYPASS |=> bypass_q == $past(tdi);
  endproperty
  a_bypass_one_bit: assert property (p_bypass_one_bit) else $error("bypass bit wrong");

  property p_restricted_blocked;
    @(posedge tck) disable iff (tap_reset) restricted && !io_taken_q |-> ir_eff == OP_BYPASS;
  endproperty
  a_restricted_blocked: assert property (p_restricted_blocked) else $error("op leaked");

  property p_tdo_tristate;
    @(posedge tck) disable iff (tap_reset)
      !tap_ctl.shift_ir && !tap_ctl.shift_dr && $past(!tap_ctl.shift_ir && !tap_ctl.shift_dr)
      |-> !tdo_oe;
  endproperty
  a_tdo_tristate: assert property (p_tdo_tristate) else $error("tdo driven idle");

  property p_init_count;
    @(posedge tck) disable iff (tap_reset)
      init_run_s && init_cnt_q != INIT_TCK_CYCLES ##1 init_run_s |-> init_cnt_q == $past(init_cnt_q) + 1'b1;
  endproperty
  a_init_count: assert property (p_init_count) else $error("init count slipped");

  property p_status_capture;
    @(posedge tck) disable iff (tap_reset) tap_ctl.capture_dr |=> status_q == $past(done_s);
  endproperty
  a_status_capture: assert property (p_status_capture) else $error("status lost");

  property p_cio_halts;
    @(posedge clk) disable iff (srst) ev[1] |=> state_q == ST_HALT ##1 cfg_clear == 1'b0;
  endproperty
  a_cio_halts: assert property (p_cio_halts) else $error("no halt on io setup");

  property p_halt_holds;
    @(posedge clk) disable iff (srst) state_q == ST_HALT && !ev[0] && !pin_rise |=> state_q == ST_HALT;
  endproperty
  a_halt_holds: assert property (p_halt_holds) else $error("left halt alone");

  property p_no_decomp;
    @(posedge clk) disable iff (srst) (state_q == ST_LOAD)[*2] |-> !decompress_en;
  endproperty
  a_no_decomp: assert property (p_no_decomp) else $error("decompress during load");

  property p_ext_abort;
    @(posedge clk) disable iff (srst)
      state_q == ST_UNCONF && state_d == ST_LOAD && pin_sys_s2_q[1] |=> ext_load_abort;
  endproperty
  a_ext_abort: assert property (p_ext_abort) else $error("other load not ended");

  property p_load_undisturbed;
    @(posedge clk) disable iff (srst)
      state_q == ST_LOAD && !ev[1] && !recfg_low && !cfg_loaded |=> state_q == ST_LOAD;
  endproperty
  a_load_undisturbed: assert property (p_load_undisturbed) else $error("load disturbed");

endmodule

// ---- rtl/jtag_cfg_pkg.sv ----
// shared constants and types of the test-port configuration loader
package jtag_cfg_pkg;

  // ---------------------------------------------------------------
  // instruction register
  // ---------------------------------------------------------------
  localparam int IR_W = 10;
  localparam logic [IR_W-1:0] IR_CAPTURE = 10'h001;
  // opcode values are arbitrary
  localparam logic [IR_W-1:0] OP_BYPASS = 10'h3ff;
  localparam logic [IR_W-1:0] OP_EXTEST = 10'h000;
  localparam logic [IR_W-1:0] OP_PULSE_CONFIG = 10'h001;
  localparam logic [IR_W-1:0] OP_PROGRAM = 10'h002;
  localparam logic [IR_W-1:0] OP_CHECK_STATUS = 10'h004;
  localparam logic [IR_W-1:0] OP_SAMPLE = 10'h005;
  localparam logic [IR_W-1:0] OP_IDCODE = 10'h006;
  localparam logic [IR_W-1:0] OP_CONFIG_IO = 10'h00d;

  // ---------------------------------------------------------------
  // widths, counts, reset values
  // ---------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int ID_W = 32;
  // identity value is arbitrary
  localparam logic [ID_W-1:0] ID_CODE_DEF = 32'h0a5a_0001;
  localparam logic [7:0] INIT_TCK_CYCLES = 8'h86;
  localparam int BSR_W_DEF = 8;
  localparam int BUF_DEPTH_DEF = 2;
  // {reconfig_n, ce_n, reset_n, oe, ext_load, ext_decomp}
  localparam logic [5:0] PIN_SYNC_RST = 6'h28;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic capture_ir;
    logic shift_ir;
    logic update_ir;
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
  } tap_ctl_type;

  typedef enum logic [4:0] {
    ST_UNCONF = 5'h01,
    ST_LOAD = 5'h02,
    ST_INIT = 5'h04,
    ST_DONE = 5'h08,
    ST_HALT = 5'h10
  } cfg_state_type;

endpackage

// ---- rtl/cfg_buffer.sv ----
// small valid/ready buffer for configuration bytes
`timescale 1ns/1ns
module cfg_buffer
  import jtag_cfg_pkg::*;
#(
  parameter int WIDTH = BYTE_W,
  parameter int DEPTH = BUF_DEPTH_DEF
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("cfg_buffer depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = cnt_q != FULL;
  assign out_valid = cnt_q != '0;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem_q[rd_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
    end else if (push && !pop) begin
      cnt_q <= cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  property p_full_refuses;
    @(posedge clk) disable iff (srst) (cnt_q == FULL && !out_ready) |=> !in_ready;
  endproperty
  a_full_refuses: assert property (p_full_refuses) else $error("buffer took data while full");

  property p_count_up;
    @(posedge clk) disable iff (srst) (push && !pop) |=> cnt_q == $past(cnt_q) + 1'b1;
  endproperty
  a_count_up: assert property (p_count_up) else $error("buffer count did not rise on push");

endmodule

// ---- tb/jtag_host_model.sv ----
// test-port host model driving framed scans
`timescale 1ns/1ns
module jtag_host_model
  import jtag_cfg_pkg::*;
(
  output logic tck,
  output logic tap_reset,
  output tap_ctl_type tap_ctl,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  logic last_q = 1'b0;
  initial begin
    tck = 1'b1;
    tap_reset = 1'b1;
    tap_ctl = '0;
    tdi = 1'b1;
  end
  // ----
  // one test clock, output read before the next rise
  // ----
  task automatic step(input tap_ctl_type c, input logic d, output logic o);
    tap_ctl <= c;
    tdi <= d;
    #62 tck = 1'b0;
    #62 o = tdo_oe ? tdo : ~last_q;
    last_q = o;
    #1 tck = 1'b1;
  endtask
  // idle clocks, also the initialization run after a bitstream
  task automatic idle(input int n);
    logic o;
    repeat (n) step('0, 1'b1, o);
  endtask
  task automatic start();
    idle(3);
    tap_reset <= 1'b0;
    idle(2);
  endtask
  // capture, n shift bits lsb first, update
  task automatic scan(input logic ir, input logic [63:0] din, input int n,
      output logic [63:0] dout);
    tap_ctl_type c;
    logic o;
    dout = '0;
    c = '0;
    c.capture_ir = ir;
    c.capture_dr = !ir;
    step(c, 1'b1, o);
    c = '0;
    c.shift_ir = ir;
    c.shift_dr = !ir;
    for (int i = 0; i < n; i++) begin
      step(c, din[i], o);
      dout[i] = o;
    end
    c = '0;
    c.update_ir = ir;
    c.update_dr = !ir;
    step(c, 1'b1, o);
  endtask
endmodule

// ---- tb/testbench.sv ----
// self-checking bench of the test-port configuration loader
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench;
  import jtag_cfg_pkg::*;
  // ----
  // signals
  // ----
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic reconfig_request_n = 1'b1;
  logic chip_enable_in_n = 1'b0;
  logic dev_reset_n = 1'b1;
  logic dev_oe = 1'b1;
  logic ext_load_active = 1'b0;
  logic ext_decomp_req = 1'b0;
  logic cfg_loaded = 1'b0;
  logic cfg_ready = 1'b1;
  logic [7:0] io_pin_in = 8'ha5;
  logic abort_seen = 1'b0;
  logic tck, tap_reset, tdi, tdo, tdo_oe, chain_enable_out_n, ext_load_abort;
  logic decompress_en, cfg_valid, cfg_clear, config_complete, io_test_en;
  logic user_oe, user_reset_n, overrun;
  logic [7:0] cfg_word, io_test_out;
  tap_ctl_type tap_ctl;
  logic [7:0] got[$];
  int n_fail = 0;
  int checks_done = 0;
  int n_clear = 0;
  always #25 clk = ~clk;
  jtag_config_loader #(.BSR_W(8)) jtag_config_loader_inst (.clk, .srst, .tck, .tap_reset,
    .tap_ctl, .tdi, .tdo, .tdo_oe, .reconfig_request_n, .chip_enable_in_n,
    .chain_enable_out_n, .dev_reset_n, .dev_oe, .ext_load_active, .ext_load_abort,
    .ext_decomp_req, .decompress_en, .cfg_loaded, .cfg_word, .cfg_valid, .cfg_ready,
    .cfg_clear, .config_complete, .io_pin_in, .io_test_out, .io_test_en, .user_oe,
    .user_reset_n, .overrun);
  jtag_host_model jtag_host_model_inst (.tck, .tap_reset, .tap_ctl, .tdi, .tdo, .tdo_oe);
  always @(posedge clk) begin
    if (cfg_valid === 1'b1 && cfg_ready === 1'b1)
      got.push_back(cfg_word);
    if (ext_load_abort === 1'b1)
      abort_seen <= 1'b1;
    if (cfg_clear === 1'b1)
      n_clear++;
  end
  // ----
  // helpers
  // ----
  task automatic wclk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic ir(input logic [IR_W-1:0] op);
    logic [63:0] d;
    jtag_host_model_inst.scan(1'b1, 64'(op), IR_W, d);
  endtask
  task automatic dr(input logic [63:0] v, input int n, output logic [63:0] d);
    jtag_host_model_inst.scan(1'b0, v, n, d);
  endtask
  task automatic load_run();
    @(posedge clk);
    cfg_loaded <= 1'b0;
    wclk(4);
    ir(OP_PROGRAM);
    wclk(10);
    cfg_loaded <= 1'b1;
    jtag_host_model_inst.idle(150);
  endtask
  task automatic complete_run();
    if (n_fail == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset_id();
    logic [63:0] d;
    `CHK(config_complete, 1'b0)
    `CHK(chain_enable_out_n, 1'b1)
    dr(64'h0, ID_W, d);
    `CHK(d[ID_W-1:0], ID_CODE_DEF)
    ir(OP_CHECK_STATUS);
    dr(64'h0, 1, d);
    `CHK(d[0], 1'b0)
    jtag_host_model_inst.scan(1'b1, 64'(OP_BYPASS), IR_W, d);
    `CHK(d[IR_W-1:0], IR_CAPTURE)
  endtask
  task automatic t_bypass();
    logic [63:0] d;
    dr(64'h5a3c, 16, d);
    `CHK(d[15:0], 16'hb478)
    `CHK(tdo_oe, 1'b0)
    ir(OP_EXTEST);
    dr(64'h5a3c, 16, d);
    `CHK(d[15:0], 16'hb478)
    `CHK(io_test_en, 1'b0)
  endtask
  task automatic t_load();
    logic [63:0] d;
    @(posedge clk);
    ext_load_active <= 1'b1;
    ext_decomp_req <= 1'b1;
    cfg_ready <= 1'b0;
    wclk(4);
    ir(OP_PROGRAM);
    wclk(10);
    `CHK(abort_seen, 1'b1)
    `CHK(decompress_en, 1'b0)
    ext_load_active <= 1'b0;
    dev_reset_n <= 1'b0;
    dev_oe <= 1'b0;
    dr(64'h332211, 24, d);
    wclk(20);
    `CHK(cfg_valid, 1'b1)
    `CHK(overrun, 1'b0)
    cfg_ready <= 1'b1;
    wclk(40);
    `CHK(got.size(), 3)
    for (int i = 0; i < 3; i++)
      `CHK(got[i], 8'(8'h11 * (i + 1)))
    ir(OP_SAMPLE);
    dr(64'h0, 8, d);
    `CHK(d[7:0], 8'ha5)
    ir(OP_IDCODE);
    dr(64'h0, ID_W, d);
    `CHK(d[ID_W-1:0], ID_CODE_DEF)
    `CHK(user_reset_n, 1'b0)
    @(posedge clk);
    dev_oe <= 1'b1;
    cfg_loaded <= 1'b1;
    jtag_host_model_inst.idle(100);
    `CHK(config_complete, 1'b0)
    jtag_host_model_inst.idle(60);
    `CHK(config_complete, 1'b1)
    `CHK(user_oe, 1'b1)
    `CHK(decompress_en, 1'b1)
    `CHK(chain_enable_out_n, 1'b0)
    ir(OP_CHECK_STATUS);
    dr(64'h0, 1, d);
    `CHK(d[0], 1'b1)
  endtask
  task automatic t_halt();
    logic [63:0] d;
    ir(OP_CONFIG_IO);
    wclk(10);
    `CHK(config_complete, 1'b0)
    dev_reset_n <= 1'b1;
    ir(OP_EXTEST);
    dr(64'h96, 8, d);
    wclk(4);
    `CHK(d[7:0], 8'ha5)
    `CHK(io_test_out, 8'h96)
    `CHK(io_test_en, 1'b1)
    jtag_host_model_inst.idle(150);
    `CHK(config_complete, 1'b0)
    ir(OP_PULSE_CONFIG);
    wclk(10);
    load_run();
    `CHK(config_complete, 1'b1)
    `CHK(user_reset_n, 1'b1)
    ir(OP_CONFIG_IO);
    wclk(10);
    reconfig_request_n <= 1'b0;
    wclk(10);
    reconfig_request_n <= 1'b1;
    wclk(10);
    load_run();
    `CHK(config_complete, 1'b1)
    reconfig_request_n <= 1'b0;
    wclk(10);
    `CHK(config_complete, 1'b0)
    reconfig_request_n <= 1'b1;
    wclk(4);
    `CHK(n_clear, 8)
  endtask
  // ----
  // main sequence and watchdog
  // ----
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    jtag_host_model_inst.start();
    t_reset_id();
    t_bypass();
    t_load();
    t_halt();
    complete_run();
  end
  initial begin
    #2000000;
    n_fail++;
    complete_run();
  end
endmodule
